// File: design/pmc_power_ctrl.sv
// pmc_power_ctrl: power-mode sequencer and system clock configuration.
// assumes firmware request strobes are one-cycle pulses on CORE_CLK and that
// wake, reset-source and oscillator pins are asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module pmc_power_ctrl
  import pmc_pkg::*;
(
  input  wire logic               CORE_CLK,
  input  wire logic               RESET_N,
  input  wire logic               IDLE_REQ,
  input  wire logic               STOP_REQ,
  input  wire logic               SUSPEND_REQ,
  input  wire logic               SNOOZE_REQ,
  input  wire logic               SHUTDOWN_SEL,
  input  wire logic               INT_PENDING,
  input  wire logic               CFG_LOAD,
  input  wire pmc_clkcfg_t        CFG_CLK,
  input  wire logic [NPERIPH-1:0] PERIPH_USE,
  input  wire logic               TMR34_LF_SEL,
  input  wire logic               TMR4_CHAIN,
  input  wire logic               T3_OVF,
  input  wire logic               TMR4_EVT,
  input  wire logic               SPI_ACT,
  input  wire logic               I2C_ACT,
  input  wire logic               PMATCH_EVT,
  input  wire logic               CMP0_OUT,
  input  wire logic               CLU_EVT,
  input  wire logic               CLU_IE,
  input  wire logic               LFOSC_IN,
  input  wire logic               OSC24_RDY,
  input  wire logic               RST_OTHER,
  input  wire logic               RST_PIN,
  input  wire logic               RST_POR,
  output pmc_mode_t               MODE,
  output pmc_pwr_t                PWR_CTL,
  output logic [NPERIPH-1:0]      PERIPH_CLK_EN,
  output pmc_clkcfg_t             SYSTEM_CLOCK_NET_CFG,
  output logic                    SYSTEM_CLOCK_NET_TICK,
  output logic                    TMR3_TICK,
  output logic                    TMR4_TICK,
  output pmc_wake_t               WAKE_SRC,
  output logic                    RESET_OUT
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic [10:0] async_in;
  logic [10:0] async_s;
  logic        spi_s;
  logic        i2c_s;
  logic        pmatch_s;
  logic        cmp0_s;
  logic        clu_s;
  logic        lf_s;
  logic        rdy_s;
  logic        rst_other_s;
  logic        rst_pin_s;
  logic        rst_por_s;
  logic        clu_ie_s;

  assign async_in = {SPI_ACT, I2C_ACT, PMATCH_EVT, CMP0_OUT, CLU_EVT, LFOSC_IN,
                     OSC24_RDY, RST_OTHER, RST_PIN, RST_POR, CLU_IE};
  assign {spi_s, i2c_s, pmatch_s, cmp0_s, clu_s, lf_s, rdy_s,
          rst_other_s, rst_pin_s, rst_por_s, clu_ie_s} = async_s;

  pmc_sync #(.W(11)) u_sync (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .d     (async_in),
    .q     (async_s)
  );

  // ----------------------------------------------------------------
  // wake detection
  // ----------------------------------------------------------------
  logic      cmp0_d;
  logic      lf_d;
  pmc_wake_t wake_vec;
  logic      any_wake;
  logic      pin_por;
  logic      any_rst;

  // edge history taken from the second synchroniser flop only
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      cmp0_d <= 1'b0;
      lf_d   <= 1'b0;
    end
    else
    begin
      cmp0_d <= cmp0_s;
      lf_d   <= lf_s;
    end
  end

  always_comb
  begin
    wake_vec.tmr4   = TMR4_EVT;
    wake_vec.spi    = spi_s;
    wake_vec.i2c    = i2c_s;
    wake_vec.pmatch = pmatch_s;
    wake_vec.cmp0   = cmp0_s && !cmp0_d; // rising edge only
    wake_vec.clu    = clu_s && clu_ie_s; // only enabled logic-unit events
  end

  assign any_wake = |wake_vec;
  assign pin_por  = rst_pin_s || rst_por_s;
  assign any_rst  = pin_por || rst_other_s;

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  pmc_mode_t  state;
  pmc_mode_t  next_state;
  logic [7:0] settle_cnt;
  logic       on_osc24;

  // suspend/snooze requests are refused unless running from 24.5 MHz,
  // since the wake path restarts only that oscillator
  assign on_osc24 = (SYSTEM_CLOCK_NET_CFG.src == SRC_OSC24);

  always_comb
  begin
    next_state = state;
    case (state)
      PM_NORMAL:
      begin
        if (STOP_REQ)
          next_state = SHUTDOWN_SEL ? PM_SHUTDOWN : PM_STOP;
        else if (SNOOZE_REQ && on_osc24)
          next_state = PM_SNOOZE;
        else if (SUSPEND_REQ && on_osc24)
          next_state = PM_SUSPEND;
        else if (IDLE_REQ)
          next_state = PM_IDLE;
      end
      PM_IDLE:
      begin
        if (INT_PENDING)
          next_state = PM_NORMAL;
      end
      PM_SUSPEND, PM_SNOOZE:
      begin
        if (any_wake)
          next_state = PM_SETTLE;
      end
      PM_SETTLE:
      begin
        if (settle_cnt == SETTLE_DONE && rdy_s)
          next_state = PM_NORMAL;
      end
      PM_STOP:
      begin
        if (any_rst)
          next_state = PM_NORMAL;
      end
      PM_SHUTDOWN:
      begin
        if (pin_por)
          next_state = PM_NORMAL;
      end
      default: next_state = PM_NORMAL;
    endcase
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      state <= PM_NORMAL;
    else
      state <= next_state;
  end

  // settle timer: loaded on wake, counts down to zero
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      settle_cnt <= SETTLE_DONE;
    else if (next_state == PM_SETTLE && state != PM_SETTLE)
      settle_cnt <= SETTLE_LOAD;
    else if (settle_cnt != SETTLE_DONE)
      settle_cnt <= settle_cnt - 8'h01;
  end

  // ----------------------------------------------------------------
  // power and clock gating outputs, registered from next mode
  // ----------------------------------------------------------------
  pmc_pwr_t next_pwr;
  logic     next_clk_on;

  always_comb
  begin
    next_pwr = '{core_clk_en: 1'b1, periph_clk_en: 1'b1, osc24_en: 1'b1,
                 osc72_en: 1'b1, reg_low_bias: 1'b0, nets_off: 1'b0, pin_hold: 1'b0};
    case (next_state)
      PM_IDLE:
        next_pwr.core_clk_en = 1'b0;
      PM_SUSPEND, PM_SNOOZE:
      begin
        next_pwr.core_clk_en   = 1'b0;
        next_pwr.periph_clk_en = 1'b0;
        next_pwr.osc24_en      = 1'b0;
        next_pwr.osc72_en      = 1'b0;
        next_pwr.reg_low_bias  = (next_state == PM_SNOOZE);
      end
      PM_SETTLE:
      begin
        // only the 24.5 MHz source restarts; clocks stay off until settled
        next_pwr.core_clk_en   = 1'b0;
        next_pwr.periph_clk_en = 1'b0;
        next_pwr.osc72_en      = 1'b0;
      end
      PM_STOP, PM_SHUTDOWN:
      begin
        next_pwr = '{core_clk_en: 1'b0, periph_clk_en: 1'b0, osc24_en: 1'b0,
                     osc72_en: 1'b0, reg_low_bias: 1'b0, nets_off: 1'b1,
                     pin_hold: 1'b1};
      end
      default: ;
    endcase
    next_clk_on = next_pwr.periph_clk_en;
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      MODE          <= PM_NORMAL;
      PWR_CTL       <= '{core_clk_en: 1'b1, periph_clk_en: 1'b1, osc24_en: 1'b1,
                         osc72_en: 1'b1, reg_low_bias: 1'b0, nets_off: 1'b0,
                         pin_hold: 1'b0};
      PERIPH_CLK_EN <= '0;
    end
    else
    begin
      MODE          <= next_state;
      PWR_CTL       <= next_pwr;
      PERIPH_CLK_EN <= PERIPH_USE & {NPERIPH{next_clk_on}};
    end
  end

  // reset request out of stop or shutdown; wake-source status latch
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      RESET_OUT <= 1'b0;
      WAKE_SRC  <= '0;
    end
    else
    begin
      RESET_OUT <= (state == PM_STOP || state == PM_SHUTDOWN) && next_state == PM_NORMAL;
      if ((state == PM_SUSPEND || state == PM_SNOOZE) && any_wake)
        WAKE_SRC <= wake_vec;
    end
  end

  // ----------------------------------------------------------------
  // system clock configuration and divider
  // ----------------------------------------------------------------
  // changes are accepted only in normal mode so a sleep never sees a
  // half-applied source switch
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
      SYSTEM_CLOCK_NET_CFG <= CLKCFG_RESET;
    else if (CFG_LOAD && state == PM_NORMAL)
    begin
      SYSTEM_CLOCK_NET_CFG       <= CFG_CLK;
      // prescale exists only for the two fast internal oscillators
      SYSTEM_CLOCK_NET_CFG.presc <= CFG_CLK.presc &&
                          (CFG_CLK.src == SRC_OSC24 || CFG_CLK.src == SRC_OSC72);
    end
  end

  pmc_clk_div u_div (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .run   (PWR_CTL.osc24_en),
    .cfg   (SYSTEM_CLOCK_NET_CFG),
    .tick  (SYSTEM_CLOCK_NET_TICK)
  );

  // ----------------------------------------------------------------
  // low-frequency timer clocking
  // ----------------------------------------------------------------
  logic [2:0] lf_cnt;
  logic       lf_tick;
  logic       lf_edge;

  assign lf_edge = lf_s && !lf_d;

  // slow oscillator divided by eight, alive in every clock-running or sleep mode
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      lf_cnt  <= 3'h0;
      lf_tick <= 1'b0;
    end
    else
    begin
      lf_tick <= lf_edge && (lf_cnt == LF_LAST);
      if (lf_edge)
        lf_cnt <= lf_cnt + 3'h1;
    end
  end

  // timer 3/4 ticks: slow source keeps counting while system_clock_net is stopped
  always_ff @(posedge CORE_CLK)
  begin
    if (!RESET_N)
    begin
      TMR3_TICK <= 1'b0;
      TMR4_TICK <= 1'b0;
    end
    else
    begin
      TMR3_TICK <= TMR34_LF_SEL ? lf_tick : SYSTEM_CLOCK_NET_TICK;
      TMR4_TICK <= TMR4_CHAIN ? T3_OVF
                 : (TMR34_LF_SEL ? lf_tick : SYSTEM_CLOCK_NET_TICK);
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_idle_core_off: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    MODE == PM_IDLE |-> !PWR_CTL.core_clk_en && PWR_CTL.periph_clk_en)
    else $error("idle clocks wrong");
  a_idle_resume: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    state == PM_IDLE && INT_PENDING |=> state == PM_NORMAL ##1 !RESET_OUT)
    else $error("idle wake wrong");
  a_suspend_off: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    MODE == PM_SUSPEND |-> !PWR_CTL.osc24_en && !PWR_CTL.osc72_en
      && !PWR_CTL.periph_clk_en && !PWR_CTL.reg_low_bias)
    else $error("suspend power wrong");
  a_snooze_bias: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    MODE == PM_SNOOZE |-> PWR_CTL.reg_low_bias && !PWR_CTL.core_clk_en)
    else $error("snooze bias wrong");
  a_wake_exit: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    (state == PM_SUSPEND || state == PM_SNOOZE) && any_wake |=> state == PM_SETTLE)
    else $error("wake missed");
  a_settle_wait: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(state == PM_SETTLE) |-> (state == PM_SETTLE)[*8])
    else $error("settle too short");
  a_stop_exit: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    state == PM_STOP && any_rst |=> state == PM_NORMAL && RESET_OUT)
    else $error("stop exit wrong");
  a_shut_hold: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    state == PM_SHUTDOWN && !pin_por |=> state == PM_SHUTDOWN && PWR_CTL.pin_hold)
    else $error("shutdown left early");
  a_reset_clock: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    $rose(RESET_N) |-> SYSTEM_CLOCK_NET_CFG == CLKCFG_RESET)
    else $error("reset clock wrong");
  a_gate_sleep: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    MODE == PM_SNOOZE |-> PERIPH_CLK_EN == '0)
    else $error("peripheral clock leak");
  a_lf_div: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    lf_edge && lf_cnt == LF_LAST && TMR34_LF_SEL && !TMR4_CHAIN |=> ##1 TMR4_TICK)
    else $error("slow tick missed");
  a_chain: assert property (@(posedge CORE_CLK) disable iff (!RESET_N)
    TMR4_CHAIN && T3_OVF |=> TMR4_TICK)
    else $error("chain tick missed");
endmodule
`default_nettype wire

// File: design/pmc_pkg.sv
// pmc_pkg: shared constants and types of the power-mode clock controller.
// assumes one 125 MHz always-on controller clock and active-low sync reset.
package pmc_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int OSC_SETTLE_NS = 2000;
  // least time: round up to whole cycles
  localparam int SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SETTLE_LOAD = 8'(SETTLE_CYC);
  localparam logic [7:0] SETTLE_DONE = 8'h00;

  // ----------------------------------------------------------------
  // clock selection and dividers
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_OSC24 = 2'h0;
  localparam logic [1:0] SRC_OSC72 = 2'h1;
  localparam logic [1:0] SRC_LFOSC = 2'h2;
  localparam logic [1:0] SRC_EXT   = 2'h3;
  localparam logic [2:0] DIV_BY8   = 3'h3;
  localparam logic [2:0] LF_LAST   = 3'h7;
  localparam logic [1:0] PRE_LAST  = 2'h2;
  localparam int         NPERIPH   = 6;

  typedef enum logic [2:0] {
    PM_NORMAL, PM_IDLE, PM_SUSPEND, PM_SNOOZE, PM_SETTLE, PM_STOP, PM_SHUTDOWN
  } pmc_mode_t;

  typedef struct packed {
    logic tmr4;
    logic spi;
    logic i2c;
    logic pmatch;
    logic cmp0;
    logic clu;
  } pmc_wake_t;

  typedef struct packed {
    logic core_clk_en;
    logic periph_clk_en;
    logic osc24_en;
    logic osc72_en;
    logic reg_low_bias;
    logic nets_off;
    logic pin_hold;
  } pmc_pwr_t;

  typedef struct packed {
    logic [1:0] src;
    logic [2:0] div;
    logic       presc;
  } pmc_clkcfg_t;

  localparam pmc_clkcfg_t CLKCFG_RESET = '{src: SRC_OSC24, div: DIV_BY8, presc: 1'b0};

endpackage

// File: design/pmc_sync.sv
// pmc_sync: two-flop level synchroniser, one bit per lane.
// assumes inputs are levels held for at least two clock periods.
`timescale 1ns/1ps
`default_nettype none
module pmc_sync
  import pmc_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta;

  // first flop feeds only the second
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

// File: design/pmc_clk_div.sv
// pmc_clk_div: system clock tick generator, optional 1.5x prescale then 2^n.
// assumes each controller cycle stands for one edge of the selected source.
`timescale 1ns/1ps
`default_nettype none
module pmc_clk_div
  import pmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire pmc_clkcfg_t cfg,
  output logic             tick
);
  logic [1:0] pre_cnt;
  logic [6:0] div_cnt;
  logic       pre_tick;

  function automatic logic [6:0] div_mask(input logic [2:0] sel);
    div_mask = 7'((8'h01 << sel) - 8'h01);
  endfunction

  // 1.5x prescale passes two of every three source edges
  assign pre_tick = run && (!cfg.presc || pre_cnt != PRE_LAST);

  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
      pre_cnt <= 2'h0;
    else if (pre_cnt == PRE_LAST)
      pre_cnt <= 2'h0;
    else
      pre_cnt <= pre_cnt + 2'h1;
  end

  // power-of-two divider, 1 to 128
  always_ff @(posedge clk)
  begin
    if (!rst_n || !run)
    begin
      div_cnt <= 7'h00;
      tick    <= 1'b0;
    end
    else
    begin
      // compare with >= so a count left above a newly loaded smaller mask
      // ends the period at once instead of running on to 127
      tick <= pre_tick && (div_cnt >= div_mask(cfg.div));
      if (pre_tick)
        div_cnt <= (div_cnt >= div_mask(cfg.div)) ? 7'h00 : div_cnt + 7'h01;
    end
  end
endmodule
`default_nettype wire

// File: testbench/test_pmc_power_ctrl.sv
// test_pmc_power_ctrl: self-checking bench for the power-mode clock controller.
// assumes pmc_pkg and the design files are compiled first; the bench drives every
// input at the falling edge of a 125 MHz clock and checks outputs there; the pulse counters sample at the rising edge.
`timescale 1ns/1ps
`default_nettype none
module test_pmc_power_ctrl
  import pmc_pkg::*;
;
  // ----------------------------------------------------------------
  // stimulus nets, counters and compare macro
  // ----------------------------------------------------------------
  logic CORE_CLK = 1'b0, RESET_N = 1'b0, IDLE_REQ = 1'b0, STOP_REQ = 1'b0, SUSPEND_REQ = 1'b0;
  logic SNOOZE_REQ = 1'b0, SHUTDOWN_SEL = 1'b0, INT_PENDING = 1'b0, CFG_LOAD = 1'b0;
  pmc_clkcfg_t CFG_CLK = CLKCFG_RESET;
  logic [NPERIPH-1:0] PERIPH_USE = '0;
  logic TMR34_LF_SEL = 1'b0, TMR4_CHAIN = 1'b0, T3_OVF = 1'b0, TMR4_EVT = 1'b0, SPI_ACT = 1'b0;
  logic I2C_ACT = 1'b0, PMATCH_EVT = 1'b0, CMP0_OUT = 1'b0, CLU_EVT = 1'b0, CLU_IE = 1'b1;
  logic LFOSC_IN = 1'b0, OSC24_RDY = 1'b1, RST_OTHER = 1'b0, RST_PIN = 1'b0, RST_POR = 1'b0;
  pmc_mode_t MODE;
  pmc_pwr_t PWR_CTL;
  logic [NPERIPH-1:0] PERIPH_CLK_EN;
  pmc_clkcfg_t SYSTEM_CLOCK_NET_CFG;
  logic SYSTEM_CLOCK_NET_TICK, TMR3_TICK, TMR4_TICK, RESET_OUT;
  pmc_wake_t WAKE_SRC;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n_sys = 0, n_t3 = 0, n_t4 = 0, n_rst = 0, n = 0;
  pmc_mode_t exp_mode;
  int exp_q[$];

`define CHECK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("wrong value at %0t ns: got %h expected %h", $time, (a), (b)); end end

  always #4 CORE_CLK = ~CORE_CLK;

  pmc_power_ctrl u_dut (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .IDLE_REQ(IDLE_REQ), .STOP_REQ(STOP_REQ),
    .SUSPEND_REQ(SUSPEND_REQ), .SNOOZE_REQ(SNOOZE_REQ), .SHUTDOWN_SEL(SHUTDOWN_SEL),
    .INT_PENDING(INT_PENDING), .CFG_LOAD(CFG_LOAD), .CFG_CLK(CFG_CLK), .PERIPH_USE(PERIPH_USE),
    .TMR34_LF_SEL(TMR34_LF_SEL), .TMR4_CHAIN(TMR4_CHAIN), .T3_OVF(T3_OVF), .TMR4_EVT(TMR4_EVT),
    .SPI_ACT(SPI_ACT), .I2C_ACT(I2C_ACT), .PMATCH_EVT(PMATCH_EVT), .CMP0_OUT(CMP0_OUT),
    .CLU_EVT(CLU_EVT), .CLU_IE(CLU_IE), .LFOSC_IN(LFOSC_IN), .OSC24_RDY(OSC24_RDY),
    .RST_OTHER(RST_OTHER), .RST_PIN(RST_PIN), .RST_POR(RST_POR), .MODE(MODE), .PWR_CTL(PWR_CTL),
    .PERIPH_CLK_EN(PERIPH_CLK_EN), .SYSTEM_CLOCK_NET_CFG(SYSTEM_CLOCK_NET_CFG), .SYSTEM_CLOCK_NET_TICK(SYSTEM_CLOCK_NET_TICK),
    .TMR3_TICK(TMR3_TICK), .TMR4_TICK(TMR4_TICK), .WAKE_SRC(WAKE_SRC), .RESET_OUT(RESET_OUT)
  );

  // pulse counters; tick outputs stand one cycle, so every rising edge is looked at
  always @(posedge CORE_CLK)
  begin
    if (SYSTEM_CLOCK_NET_TICK === 1'b1) n_sys++;
    if (TMR3_TICK === 1'b1) n_t3++;
    if (TMR4_TICK === 1'b1) n_t4++;
    if (RESET_OUT === 1'b1) n_rst++;
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic tick(input int c);
    repeat (c) @(negedge CORE_CLK);
  endtask

  task automatic clear_counts();
    {n_sys, n_t3, n_t4, n_rst} = '0;
  endtask

  // one-cycle firmware request: 0 idle, 1 suspend, 2 snooze, 3 stop
  task automatic req(input int k);
    @(negedge CORE_CLK);
    case (k)
      0: IDLE_REQ = 1'b1;
      1: SUSPEND_REQ = 1'b1;
      2: SNOOZE_REQ = 1'b1;
      default: STOP_REQ = 1'b1;
    endcase
    @(negedge CORE_CLK);
    {IDLE_REQ, SUSPEND_REQ, SNOOZE_REQ, STOP_REQ} = '0;
  endtask

  task automatic wait_mode(input pmc_mode_t m, input int lim);
    n = 0;
    while (MODE !== m && n < lim)
    begin
      @(negedge CORE_CLK);
      n++;
    end
  endtask

  task automatic load_cfg(input logic [1:0] s, input logic [2:0] d, input logic p);
    @(negedge CORE_CLK);
    CFG_CLK = '{src: s, div: d, presc: p};
    CFG_LOAD = 1'b1;
    @(negedge CORE_CLK);
    CFG_LOAD = 1'b0;
  endtask

  // wake source lanes in the order of the wake record, tmr4 first
  task automatic set_src(input int s, input logic v);
    case (s)
      0: TMR4_EVT = v;
      1: SPI_ACT = v;
      2: I2C_ACT = v;
      3: PMATCH_EVT = v;
      4: CMP0_OUT = v;
      default: CLU_EVT = v;
    endcase
  endtask

  // sleep, wake by one source, and let the fast oscillator settle after rdy_dly cycles
  task automatic sleep_wake(input int k, input int s, input int rdy_dly);
    req(k);
    OSC24_RDY = 1'b0;
    `CHECK(MODE, (k == 2) ? PM_SNOOZE : PM_SUSPEND)
    `CHECK({PWR_CTL.core_clk_en, PWR_CTL.periph_clk_en, PWR_CTL.osc24_en, PWR_CTL.osc72_en}, 4'h0)
    `CHECK(PWR_CTL.reg_low_bias, (k == 2))
    tick(3 + $urandom % 8);
    `CHECK(PERIPH_CLK_EN, 6'h00)
    `CHECK(MODE, (k == 2) ? PM_SNOOZE : PM_SUSPEND)
    set_src(s, 1'b1);
    wait_mode(PM_SETTLE, 6);
    `CHECK(MODE, PM_SETTLE)
    `CHECK(WAKE_SRC, pmc_wake_t'(6'h20 >> s))
    `CHECK({PWR_CTL.osc24_en, PWR_CTL.core_clk_en}, 2'h2)
    tick(3);
    set_src(s, 1'b0);
    tick(rdy_dly);
    // oscillator not ready yet, so the settle wait must still hold
    `CHECK(MODE, PM_SETTLE)
    OSC24_RDY = 1'b1;
    wait_mode(PM_NORMAL, 300);
    exp_q.push_back(rdy_dly > 260 ? 3 : SETTLE_CYC - rdy_dly - 3);
    `CHECK(n >= exp_q[$] - 2 && n <= exp_q[$] + 6, 1'b1)
    `CHECK({PWR_CTL.core_clk_en, PWR_CTL.periph_clk_en}, 2'h3)
  endtask

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: the whole sequence needs well under 20000 cycles
  // ----------------------------------------------------------------
  initial
  begin
    repeat (40000) @(posedge CORE_CLK);
    n_mismatch++;
    complete_run();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    void'($urandom(90515));
    tick(8);
    RESET_N = 1'b1;
    tick(1);
    clear_counts();
    `CHECK(SYSTEM_CLOCK_NET_CFG, CLKCFG_RESET)
    `CHECK(MODE, PM_NORMAL)
    tick(128);
    `CHECK(n_sys >= 15 && n_sys <= 17, 1'b1)
    $display("test reset defaults done");
    // random peripheral use; clock enables follow one cycle later
    for (int i = 0; i < 8; i++)
    begin
      PERIPH_USE = NPERIPH'($urandom);
      tick(2);
      `CHECK(PERIPH_CLK_EN, PERIPH_USE)
    end
    req(0);
    exp_mode = PM_IDLE;
    `CHECK(MODE, exp_mode)
    `CHECK({PWR_CTL.core_clk_en, PWR_CTL.periph_clk_en}, 2'h1)
    tick(5);
    `CHECK(PERIPH_CLK_EN, PERIPH_USE)
    clear_counts();
    INT_PENDING = 1'b1;
    tick(1);
    INT_PENDING = 1'b0;
    `CHECK(MODE, PM_NORMAL)
    `CHECK(n_rst, 0)
    $display("test idle done");
    // sleep is refused while the system clock is not the 24.5 MHz source
    load_cfg(SRC_OSC72, DIV_BY8, 1'b0);
    req(1);
    `CHECK(MODE, PM_NORMAL)
    load_cfg(SRC_OSC24, DIV_BY8, 1'b0);
    // a logic-unit event with its interrupt disabled must not wake
    CLU_IE = 1'b0;
    req(1);
    CLU_EVT = 1'b1;
    tick(6);
    CLU_EVT = 1'b0;
    `CHECK(MODE, PM_SUSPEND)
    tick(3);
    CLU_IE = 1'b1;
    PMATCH_EVT = 1'b1;
    wait_mode(PM_SETTLE, 6);
    PMATCH_EVT = 1'b0;
    wait_mode(PM_NORMAL, 300);
    `CHECK(MODE, PM_NORMAL)
    for (int s = 0; s < 6; s++)
      sleep_wake(1, s, $urandom % 120);
    sleep_wake(2, $urandom % 6, 0);
    sleep_wake(2, 4, 300);
    $display("test suspend and snooze done");
    // stop exits on any reset source; shutdown ignores the other sources
    for (int k = 0; k < 3; k++)
    begin
      SHUTDOWN_SEL = (k != 0);
      req(3);
      SHUTDOWN_SEL = 1'b0;
      `CHECK(MODE, (k == 0) ? PM_STOP : PM_SHUTDOWN)
      `CHECK({PWR_CTL.nets_off, PWR_CTL.pin_hold}, 2'h3)
      clear_counts();
      RST_OTHER = 1'b1;
      tick(4);
      RST_OTHER = 1'b0;
      if (k != 0)
      begin
        tick(6);
        `CHECK(MODE, PM_SHUTDOWN)
        if (k == 1) RST_PIN = 1'b1; else RST_POR = 1'b1;
        tick(4);
        {RST_PIN, RST_POR} = '0;
      end
      wait_mode(PM_NORMAL, 8);
      tick(2);
      `CHECK(MODE, PM_NORMAL)
      `CHECK(n_rst, 1)
    end
    $display("test stop and shutdown done");
    // every divider setting, then the 1.5x prescale on both fast sources
    for (int d = 0; d < 8; d++)
    begin
      load_cfg(SRC_OSC24, 3'(d), 1'b0);
      `CHECK(SYSTEM_CLOCK_NET_CFG.div, 3'(d))
      clear_counts();
      tick(512);
      `CHECK(n_sys >= (512 >> d) - 1 && n_sys <= (512 >> d) + 1, 1'b1)
    end
    for (int s = 0; s < 3; s++)
    begin
      load_cfg(2'(s), 3'h0, 1'b1);
      `CHECK(SYSTEM_CLOCK_NET_CFG.presc, (s < 2))
    end
    load_cfg(SRC_OSC24, 3'h0, 1'b1);
    clear_counts();
    tick(384);
    `CHECK(n_sys >= 254 && n_sys <= 258, 1'b1)
    load_cfg(SRC_OSC24, DIV_BY8, 1'b0);
    $display("test divider done");
    // slow oscillator divided by eight, then timer 4 chained to timer 3;
    // let a system tick already in flight on the timer outputs drain first
    TMR34_LF_SEL = 1'b1;
    tick(2);
    clear_counts();
    repeat (16)
    begin
      LFOSC_IN = 1'b1;
      tick(4);
      LFOSC_IN = 1'b0;
      tick(4);
    end
    tick(6);
    `CHECK(n_t3, 2)
    `CHECK(n_t4, 2)
    TMR34_LF_SEL = 1'b0;
    TMR4_CHAIN = 1'b1;
    clear_counts();
    repeat (3)
    begin
      T3_OVF = 1'b1;
      tick(1);
      T3_OVF = 1'b0;
      tick(4);
    end
    `CHECK(n_t4, 3)
    $display("test slow timers done");
    complete_run();
  end

endmodule
`default_nettype wire
